// ==== pkg/qdc_defs.vh ====
// Register map, field positions, reset values and timing counts of the quadrature decoder
// ==========================================================================
`ifndef QDC_DEFS_VH
`define QDC_DEFS_VH

// ==========================================================================
// Register byte offsets
`define QDC_OFS_CONTROL      12'h000
`define QDC_OFS_DIVIDER      12'h004
`define QDC_OFS_MODE_CONTROL 12'h008
`define QDC_OFS_X_COUNT      12'h00c
`define QDC_OFS_Y_COUNT      12'h010
`define QDC_OFS_Z_COUNT      12'h014
`define QDC_OFS_EDGE_COUNT   12'h018

// ==========================================================================
// decoder_control fields
`define QDC_CTL_THR_LSB      0
`define QDC_CTL_THR_MSB      7
`define QDC_CTL_IRQ_BIT      8
`define QDC_CTL_CLR_BIT      9
`define QDC_CTL_LPCLK_BIT    10

// decoder_mode_control fields: per axis 4-bit pin select at 8*axis, mode at 8*axis+4,
// enable at 8*axis+5
`define QDC_MODE_AXIS_STRIDE 8
`define QDC_MODE_MODE_OFS    4
`define QDC_MODE_EN_OFS      5

// ==========================================================================
// Reset values
`define QDC_RST_THRESHOLD    8'h01
`define QDC_RST_DIVIDER      10'h000
`define QDC_RST_MODE_CONTROL 24'h000000

// ==========================================================================
// Timing: 20 MHz clock caps sampling at 16 MHz by forcing at least one extra cycle, except with the low-power clock flag, which samples every cycle
`define QDC_CLK_HZ           20000000
`define QDC_MAX_SAMPLE_HZ    16000000
`define QDC_MIN_DIV_CYCLES   ((`QDC_CLK_HZ + `QDC_MAX_SAMPLE_HZ - 1) / `QDC_MAX_SAMPLE_HZ)
`define QDC_FILTER_SAMPLES   3

`endif

// ==== logic/qdc_channel_filter.v ====
// Spike filter and edge detector for one decoder channel input
`timescale 1ns/1ns
module qdc_channel_filter #(
  parameter SAMPLES = 3
) (
  input  wire clk,        // System clock
  input  wire rst_b,      // Synchronous reset, active low
  input  wire sample,     // Sampling strobe from divider
  input  wire raw,        // Synchronised channel level
  output reg  level_q,    // Filtered level
  output reg  edge_q      // One-cycle pulse on filtered change
);

  reg [SAMPLES-1:0] hist_q;

  // ========================================================================
  // Level accepted only after SAMPLES equal samples
  always @(posedge clk) begin
    if (!rst_b) begin
      hist_q  <= {SAMPLES{1'b0}};
      level_q <= 1'b0;
      edge_q  <= 1'b0;
    end else begin
      edge_q <= 1'b0;
      if (sample) begin
        hist_q <= {hist_q[SAMPLES-2:0], raw};
        if (({hist_q[SAMPLES-2:0], raw} == {SAMPLES{~level_q}})) begin
          level_q <= ~level_q;
          edge_q  <= 1'b1;
        end
      end
    end
  end

endmodule // qdc_channel_filter

// ==== logic/qdc_quad_decoder.v ====
// Three-axis quadrature decoder with APB register access
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "qdc_defs.vh"
module qdc_quad_decoder #(
  parameter NUM_PINS = 12,
  parameter DIV_W    = 10
) (
  input  wire                clk,         // System clock, 20 MHz
  input  wire                rst_b,       // Synchronous reset, active low
  input  wire [NUM_PINS-1:0] gpio_in,     // Pad levels, asynchronous
  input  wire [11:0]         paddr,       // APB address
  input  wire                psel,        // APB select
  input  wire                penable,     // APB enable
  input  wire                pwrite,      // APB direction
  input  wire [31:0]         pwdata,      // APB write data
  output reg  [31:0]         prdata,      // APB read data
  output reg                 pready,      // APB ready
  output reg                 pslverr,     // APB error on unmapped address
  output reg                 irq_q        // Threshold interrupt and wake request
);

  // ========================================================================
  // Pad synchronisers
  reg [NUM_PINS-1:0] sync1_q;
  reg [NUM_PINS-1:0] sync2_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      sync1_q <= {NUM_PINS{1'b0}};
      sync2_q <= {NUM_PINS{1'b0}};
    end else begin
      sync1_q <= gpio_in;
      sync2_q <= sync1_q;
    end
  end

  // ========================================================================
  // Registers
  reg [7:0]       thr_q;
  reg             lpclk_q;
  reg [DIV_W-1:0] div_q;
  reg [23:0]      modectl_q;
  reg [7:0]       edge_cnt_q;
  reg             pend_q;
  reg [15:0]      axis_cnt_q [0:2];

  // ========================================================================
  // Sampling divider
  reg [DIV_W-1:0] div_cnt_q;
  reg             sample_q;
  wire [DIV_W-1:0] div_eff;
  wire [31:0]      div_floor;
  wire [31:0]      div_q_ext;
  // Floor keeps the sampling rate under the cap even for a zero divider while lpclk_q is clear
  assign div_floor = `QDC_MIN_DIV_CYCLES - 1;
  assign div_q_ext = {{(32-DIV_W){1'b0}}, div_q};
  assign div_eff   = (div_q_ext < div_floor) ? div_floor[DIV_W-1:0] : div_q;

  always @(posedge clk) begin
    if (!rst_b) begin
      div_cnt_q <= {DIV_W{1'b0}};
      sample_q  <= 1'b0;
    end else if (lpclk_q) begin
      div_cnt_q <= {DIV_W{1'b0}};
      sample_q  <= 1'b1;
    end else if (div_cnt_q >= div_eff) begin
      div_cnt_q <= {DIV_W{1'b0}};
      sample_q  <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      sample_q  <= 1'b0;
    end
  end

  // ========================================================================
  // Per-axis pin select, filter, decode
  wire [2:0] axis_en;
  wire [2:0] axis_any_edge;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      wire [3:0] sel;
      wire       quad_mode;
      wire       a_raw;
      wire       b_raw;
      wire       a_lvl;
      wire       b_lvl;
      wire       a_edge;
      wire       b_edge;
      reg        a_prev_q;
      reg        b_prev_q;
      assign sel       = modectl_q[g*`QDC_MODE_AXIS_STRIDE +: 4];
      assign quad_mode = ~modectl_q[g*`QDC_MODE_AXIS_STRIDE + `QDC_MODE_MODE_OFS];
      assign axis_en[g] = modectl_q[g*`QDC_MODE_AXIS_STRIDE + `QDC_MODE_EN_OFS];
      // Pair is pin sel and sel+1, wrapping at the top
      assign a_raw = sync2_q[sel % NUM_PINS];
      assign b_raw = sync2_q[(sel + 1) % NUM_PINS];

      qdc_channel_filter #(.SAMPLES(`QDC_FILTER_SAMPLES)) u_fa (
        .clk     (clk),
        .rst_b   (rst_b),
        .sample  (sample_q),
        .raw     (a_raw),
        .level_q (a_lvl),
        .edge_q  (a_edge)
      );
      qdc_channel_filter #(.SAMPLES(`QDC_FILTER_SAMPLES)) u_fb (
        .clk     (clk),
        .rst_b   (rst_b),
        .sample  (sample_q),
        .raw     (b_raw),
        .level_q (b_lvl),
        .edge_q  (b_edge)
      );

      assign axis_any_edge[g] = axis_en[g] & (a_edge | b_edge);

      // Direction from phase lead: A changes with A==B before -> forward
      always @(posedge clk) begin
        if (!rst_b) begin
          a_prev_q      <= 1'b0;
          b_prev_q      <= 1'b0;
          axis_cnt_q[g] <= 16'h0000;
        end else if (!axis_en[g]) begin
          a_prev_q      <= a_lvl;
          b_prev_q      <= b_lvl;
          axis_cnt_q[g] <= 16'h0000;
        end else begin
          a_prev_q <= a_lvl;
          b_prev_q <= b_lvl;
          if (a_edge | b_edge) begin
            if (!quad_mode) begin
              axis_cnt_q[g] <= axis_cnt_q[g] + 16'h0001;
            end else if (a_edge & ~b_edge) begin
              if (a_lvl != b_prev_q) axis_cnt_q[g] <= axis_cnt_q[g] + 16'h0001;
              else axis_cnt_q[g] <= axis_cnt_q[g] - 16'h0001;
            end else if (b_edge & ~a_edge) begin
              if (b_lvl == a_prev_q) axis_cnt_q[g] <= axis_cnt_q[g] + 16'h0001;
              else axis_cnt_q[g] <= axis_cnt_q[g] - 16'h0001;
            end
            // In quadrature mode both channels together carry no direction: hold
          end
        end
      end
    end
  endgenerate

  // ========================================================================
  // APB slave, one wait state
  wire apb_acc;
  wire apb_wr;
  wire clr_wr;
  wire irq_wr;
  wire any_edge;
  wire hit;
  assign apb_acc = psel & penable & ~pready;
  assign apb_wr  = apb_acc & pwrite & (paddr == `QDC_OFS_CONTROL);
  assign irq_wr  = apb_wr & pwdata[`QDC_CTL_IRQ_BIT];
  assign clr_wr  = apb_wr & pwdata[`QDC_CTL_CLR_BIT];
  assign any_edge = |axis_any_edge;
  assign hit = (paddr == `QDC_OFS_CONTROL) | (paddr == `QDC_OFS_DIVIDER) |
               (paddr == `QDC_OFS_MODE_CONTROL) | (paddr == `QDC_OFS_X_COUNT) |
               (paddr == `QDC_OFS_Y_COUNT) | (paddr == `QDC_OFS_Z_COUNT) |
               (paddr == `QDC_OFS_EDGE_COUNT);

  always @(posedge clk) begin
    if (!rst_b) begin
      thr_q     <= `QDC_RST_THRESHOLD;
      lpclk_q   <= 1'b0;
      div_q     <= `QDC_RST_DIVIDER;
      modectl_q <= `QDC_RST_MODE_CONTROL;
    end else if (apb_acc & pwrite) begin
      case (paddr)
        `QDC_OFS_CONTROL: begin
          thr_q   <= pwdata[`QDC_CTL_THR_MSB:`QDC_CTL_THR_LSB];
          lpclk_q <= pwdata[`QDC_CTL_LPCLK_BIT];
        end
        `QDC_OFS_DIVIDER:      div_q     <= pwdata[DIV_W-1:0];
        `QDC_OFS_MODE_CONTROL: modectl_q <= pwdata[23:0];
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Edge counter and threshold interrupt
  always @(posedge clk) begin
    if (!rst_b) begin
      edge_cnt_q <= 8'h00;
    end else if (any_edge) begin
      // A simultaneous clear still applies and the edge counts from zero, so no event is lost
      edge_cnt_q <= (clr_wr ? 8'h00 : edge_cnt_q) + 8'h01;
    end else if (clr_wr) begin
      edge_cnt_q <= 8'h00;
    end
  end

  wire thr_hit;
  assign thr_hit = any_edge & ((clr_wr ? 8'h00 : edge_cnt_q) + 8'h01 == thr_q);

  always @(posedge clk) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      if (thr_hit) pend_q <= 1'b1;
      else if (irq_wr) pend_q <= 1'b0;
      irq_q <= thr_hit | (pend_q & ~irq_wr);
    end
  end

  // ========================================================================
  // Read mux and handshake
  always @(posedge clk) begin
    if (!rst_b) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= apb_acc & ~hit;
      prdata  <= 32'h00000000;
      if (apb_acc & ~pwrite) begin
        case (paddr)
          `QDC_OFS_CONTROL:
            prdata <= {21'h000000, lpclk_q, 1'b0, pend_q, thr_q};
          `QDC_OFS_DIVIDER:      prdata <= {{(32-DIV_W){1'b0}}, div_q};
          `QDC_OFS_MODE_CONTROL: prdata <= {8'h00, modectl_q};
          `QDC_OFS_X_COUNT:      prdata <= {16'h0000, axis_cnt_q[0]};
          `QDC_OFS_Y_COUNT:      prdata <= {16'h0000, axis_cnt_q[1]};
          `QDC_OFS_Z_COUNT:      prdata <= {16'h0000, axis_cnt_q[2]};
          `QDC_OFS_EDGE_COUNT:   prdata <= {24'h000000, edge_cnt_q};
          default:               prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // qdc_quad_decoder

// ==== verification/qdc_quad_decoder_sva.sv ====
// Port-level checker for the quadrature decoder, bound to its top module
`timescale 1ns/1ns
`include "qdc_defs.vh"
module qdc_quad_decoder_sva #(
  parameter NUM_PINS = 12
) (
  input wire logic                clk,     // System clock
  input wire logic                rst_b,   // Reset, active low
  input wire logic [NUM_PINS-1:0] gpio_in, // Pad levels
  input wire logic [11:0]         paddr,   // APB address
  input wire logic                psel,    // APB select
  input wire logic                penable, // APB enable
  input wire logic                pwrite,  // APB direction
  input wire logic [31:0]         pwdata,  // APB write data
  input wire logic [31:0]         prdata,  // APB read data
  input wire logic                pready,  // APB ready
  input wire logic                pslverr, // APB error
  input wire logic                irq_q    // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Helpers
  wire acc = psel && penable && !pready;
  wire clr_pend = acc && pwrite && paddr == `QDC_OFS_CONTROL && pwdata[8];
  wire rd_done = pready && !pwrite;
  // ==========================================================================
  // Assertions
  ready_after_wait_a: assert property (acc |=> pready)
    else $error("no ready one cycle after access");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(acc))
    else $error("ready without access");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr > `QDC_OFS_EDGE_COUNT))
    else $error("error flag wrong for address");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !irq_q && !pready)
    else $error("outputs active after reset edge");
  pending_hold_a: assert property (irq_q && !clr_pend |=> irq_q)
    else $error("pending dropped without clear");
  pending_read_a: assert property (rd_done && paddr == `QDC_OFS_CONTROL
    |-> prdata[8] == $past(irq_q) && !prdata[9])
    else $error("control read wrong");
  edge_width_a: assert property (rd_done && paddr == `QDC_OFS_EDGE_COUNT
    |-> prdata[31:8] == 24'h0)
    else $error("edge count wider than 8 bits");
  axis_width_a: assert property (rd_done && paddr >= `QDC_OFS_X_COUNT
    && paddr <= `QDC_OFS_Z_COUNT |-> prdata[31:16] == 16'h0)
    else $error("axis count wider than 16 bits");
  cover property ($rose(irq_q));
  cover property (pready && pslverr);
  cover property (clr_pend && irq_q);
endmodule // qdc_quad_decoder_sva

bind qdc_quad_decoder qdc_quad_decoder_sva #(.NUM_PINS(NUM_PINS)) u_sva (.clk(clk),
  .rst_b(rst_b), .gpio_in(gpio_in), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq_q(irq_q));

// ==== verification/qdc_motion_model.sv ====
// Behavioural motion device driving one quadrature pin pair over pad noise
`timescale 1ns/1ns
module qdc_motion_model (
  input  wire        clk,   // Bench clock
  input  wire        step,  // One quadrature step
  input  wire        dir,   // 1 moves forward
  input  wire        both,  // Flip both channels at once
  input  wire        spike, // One-clock glitch on channel A
  input  wire [3:0]  pin,   // Channel A pad index
  input  wire [11:0] noise, // Levels of the other pads
  output reg  [11:0] gpio   // Pad levels
);
  reg  [1:0] ph_q  = 2'h0;
  reg        spk_q = 1'b0;
  wire [3:0] pin_b = (pin == 4'hb) ? 4'h0 : pin + 4'h1;
  // Gray phase; counting up makes A lead B
  always @(posedge clk) begin
    spk_q <= spike;
    if (step)
      ph_q <= dir ? ph_q + 2'h1 : ph_q - 2'h1;
    else if (both)
      ph_q <= ph_q + 2'h2;
  end
  always @* begin
    gpio = noise;
    gpio[pin] = ph_q[1] ^ ph_q[0] ^ spk_q;
    gpio[pin_b] = ph_q[1];
  end
endmodule // qdc_motion_model

// ==== verification/quadrature_decoder_three_axis_tb_top.sv ====
// Self-checking testbench for the three-axis quadrature decoder
`timescale 1ns/1ns
`include "qdc_defs.vh"
module quadrature_decoder_three_axis_tb_top;
  reg         clk, rst_b, psel, penable, pwrite, step, dir, both, spike;
  reg  [11:0] paddr, noise;
  reg  [31:0] pwdata, rd;
  reg  [3:0]  pin;
  wire [11:0] gpio;
  wire [31:0] prdata;
  wire        pready, pslverr, irq_q;
  integer     err_count, cmp_count, n, m, t, k, p;
  qdc_quad_decoder dut (.clk(clk), .rst_b(rst_b), .gpio_in(gpio), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_q(irq_q));
  qdc_motion_model model (.clk(clk), .step(step), .dir(dir), .both(both), .spike(spike),
    .pin(pin), .noise(noise), .gpio(gpio));
  function [15:0] exp_q(input integer f, input integer b);
    exp_q = f - b;
  endfunction
  function [31:0] exp_e(input integer c);
    exp_e = c % 256;
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      @(posedge clk);
      while (pready !== 1'b1 && i < 20) begin
        @(posedge clk);
        i = i + 1;
      end
      rd = prdata;
      chk({pready, pslverr}, {1'b1, a > `QDC_OFS_EDGE_COUNT});
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, e);
    end
  endtask
  task steps(input integer c, input d, input b);
    repeat (c) begin
      @(posedge clk);
      step <= ~b; both <= b; dir <= d;
      @(posedge clk);
      step <= 1'b0; both <= 1'b0;
      repeat (16) @(posedge clk);
    end
  endtask
  task stop_test;
    begin
      $display("Checks %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ==========================================================================
  // Clock, pad noise, watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Unselected pads toggle freely; they must never count
  always @(posedge clk) noise <= $urandom;
  initial begin
    repeat (20000) @(posedge clk);
    err_count = err_count + 1;
    stop_test;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    err_count = 0; cmp_count = 0;
    rd = $urandom(32'hfa2fda0a);
    {psel, penable, pwrite, step, dir, both, spike} = 7'h0;
    paddr = 12'h0; pwdata = 32'h0; pin = 4'h0; rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rdc(`QDC_OFS_CONTROL, 32'h1);
    rdc(`QDC_OFS_MODE_CONTROL, 32'h0);
    rdc(`QDC_OFS_X_COUNT, 32'h0);
    rdc(12'h01c, 32'h0);
    n = $urandom % 8 + 8; m = n + $urandom % 4 + 1; t = $urandom % 10 + 5;
    k = $urandom % 5 + 3; p = $urandom % 12; pin <= p;
    apb(1'b1, `QDC_OFS_DIVIDER, 32'h1);
    apb(1'b1, `QDC_OFS_CONTROL, t);
    // Select pins while disabled so the filters settle on the new pads first
    apb(1'b1, `QDC_OFS_MODE_CONTROL, p | (p << 8));
    repeat (16) @(posedge clk);
    apb(1'b1, `QDC_OFS_MODE_CONTROL, 32'h20 | p | (p << 8));
    steps(n, 1'b1, 1'b0);
    steps(m, 1'b0, 1'b0);
    rdc(`QDC_OFS_X_COUNT, exp_q(n, m));
    rdc(`QDC_OFS_EDGE_COUNT, exp_e(n + m));
    rdc(`QDC_OFS_CONTROL, 32'h100 | t);
    spike <= 1'b1;
    @(posedge clk);
    spike <= 1'b0;
    // Glitch must be gone before both channels move together
    repeat (8) @(posedge clk);
    steps(1, 1'b1, 1'b1);
    rdc(`QDC_OFS_X_COUNT, exp_q(n, m));
    rdc(`QDC_OFS_EDGE_COUNT, exp_e(n + m + 1));
    apb(1'b1, `QDC_OFS_CONTROL, 32'h300 | t);
    chk(irq_q, 32'h0);
    rdc(`QDC_OFS_EDGE_COUNT, 32'h0);
    apb(1'b1, `QDC_OFS_MODE_CONTROL, p | (p << 8));
    rdc(`QDC_OFS_X_COUNT, 32'h0);
    // Slow divider must be ignored once the low-power clock flag is set
    apb(1'b1, `QDC_OFS_DIVIDER, 32'h3ff);
    apb(1'b1, `QDC_OFS_CONTROL, 32'h400 | t);
    apb(1'b1, `QDC_OFS_MODE_CONTROL, 32'h3000 | (p << 8) | p);
    steps(k, 1'b1, 1'b0);
    steps(1, 1'b1, 1'b1);
    apb(1'b1, `QDC_OFS_Y_COUNT, 32'hffff);
    rdc(`QDC_OFS_Y_COUNT, k + 1);
    rdc(`QDC_OFS_EDGE_COUNT, exp_e(k + 1));
    chk(irq_q, k + 1 >= t);
    stop_test;
  end
endmodule // quadrature_decoder_three_axis_tb_top
